/* rtl/tmps_port_select.sv */
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
module tmps_port_select (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // lookup result from search engine
    input  wire logic        lk_valid,
    input  wire logic        lk_multicast,
    input  wire logic [47:0] lk_src_mac,
    input  wire logic [47:0] lk_dst_mac,
    input  wire logic [3:0]  lk_src_port,
    input  wire logic [9:0]  lk_dest_set,
    input  wire logic        lk_dst_is_trunk,
    input  wire logic [2:0]  lk_dst_trunk,
    input  wire logic        lk_src_mirror,
    input  wire logic        lk_dst_mirror,
    input  wire logic        lk_ring_mode,
    // decision to queue manager
    output logic             qm_valid,
    output logic [9:0]       qm_dest_set,
    output logic [9:0]       qm_mirror_set,
    output logic             qm_drop
);
    // ==========================================================
    // register state
    logic [7:0]  member   [tmps_pkg::TMPS_NUM_GROUPS];
    logic [2:0]  sel_tbl  [tmps_pkg::TMPS_NUM_GROUPS*tmps_pkg::TMPS_NUM_ENTRIES];
    logic [31:0] hash_ctrl;
    logic [31:0] mirror_ctrl;
    logic [47:0] flow_a;
    logic [47:0] flow_b;
    logic [15:0] drop_count;
    logic [15:0] mirror_count;
    // ==========================================================
    // ahb address phase capture
    logic        wr_pend;
    logic [7:0]  ph_addr;
    logic        take;
    assign take = hsel & hready & htrans[1];

    // single wait-free data phase; writes land at end of data phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend <= 1'b0;
            ph_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= take & hwrite;
            ph_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // control register writes; select table rewritten on failover
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hash_ctrl   <= tmps_pkg::TMPS_HASH_RST;
            mirror_ctrl <= tmps_pkg::TMPS_MIRROR_RST;
            flow_a      <= 48'h0000_0000_0000;
            flow_b      <= 48'h0000_0000_0000;
            for (int g = 0; g < tmps_pkg::TMPS_NUM_GROUPS; g++) begin
                member[g] <= 8'h00;
            end
            for (int e = 0; e < tmps_pkg::TMPS_NUM_GROUPS*tmps_pkg::TMPS_NUM_ENTRIES; e++) begin
                sel_tbl[e] <= 3'h0;
            end
        end else if (wr_pend) begin
            if (ph_addr < tmps_pkg::TMPS_OFS_HASH_CTRL) begin
                member[ph_addr[4:2]] <= hwdata[7:0];
            end else if (ph_addr >= tmps_pkg::TMPS_OFS_SELECT &&
                         ph_addr < 8'hc0) begin
                sel_tbl[6'(ph_addr[7:2] - 6'h10)] <= hwdata[2:0];
            end else begin
                unique case (ph_addr)
                    tmps_pkg::TMPS_OFS_HASH_CTRL:   hash_ctrl   <= {30'h0, hwdata[1:0]};
                    tmps_pkg::TMPS_OFS_MIRROR_CTRL: mirror_ctrl <= {8'h00, hwdata[23:0]};
                    tmps_pkg::TMPS_OFS_FLOW_A_LO:   flow_a[31:0]  <= hwdata;
                    tmps_pkg::TMPS_OFS_FLOW_A_HI:   flow_a[47:32] <= hwdata[15:0];
                    tmps_pkg::TMPS_OFS_FLOW_B_LO:   flow_b[31:0]  <= hwdata;
                    tmps_pkg::TMPS_OFS_FLOW_B_HI:   flow_b[47:32] <= hwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // read data registered at the address phase edge; unmapped reads return zero
    logic [31:0] next_hrdata;
    logic [7:0]  cur_addr;
    always_comb begin
        cur_addr    = haddr[7:0];
        next_hrdata = 32'h0000_0000;
        if (cur_addr < tmps_pkg::TMPS_OFS_HASH_CTRL) begin
            next_hrdata = {24'h0, member[cur_addr[4:2]]};
        end else if (cur_addr >= tmps_pkg::TMPS_OFS_SELECT && cur_addr < 8'hc0) begin
            next_hrdata = {29'h0, sel_tbl[6'(cur_addr[7:2] - 6'h10)]};
        end else begin
            unique case (cur_addr)
                tmps_pkg::TMPS_OFS_HASH_CTRL:   next_hrdata = hash_ctrl;
                tmps_pkg::TMPS_OFS_MIRROR_CTRL: next_hrdata = mirror_ctrl;
                tmps_pkg::TMPS_OFS_FLOW_A_LO:   next_hrdata = flow_a[31:0];
                tmps_pkg::TMPS_OFS_FLOW_A_HI:   next_hrdata = {16'h0, flow_a[47:32]};
                tmps_pkg::TMPS_OFS_FLOW_B_LO:   next_hrdata = flow_b[31:0];
                tmps_pkg::TMPS_OFS_FLOW_B_HI:   next_hrdata = {16'h0, flow_b[47:32]};
                tmps_pkg::TMPS_OFS_STATUS:      next_hrdata = {mirror_count, drop_count};
                default:                        next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (take & ~hwrite) begin
            hrdata <= next_hrdata;
        end else begin
            hrdata <= 32'h0000_0000; // zero outside a read data phase
        end
    end

    // ==========================================================
    // hash key: xor-fold of selected fields, pure function of the frame
    tmps_pkg::tmps_hash_t mode;
    logic [47:0] fold_src;
    logic [2:0]  key;
    function automatic logic [2:0] fold48(input logic [47:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 16; i++) begin
            r = r ^ v[i*3 +: 3];
        end
        return r;
    endfunction

    always_comb begin
        mode     = tmps_pkg::tmps_hash_t'(hash_ctrl[1:0]);
        fold_src = lk_src_mac ^ lk_dst_mac;
        unique case (mode)
            tmps_pkg::TMPS_HASH_SRC_DST: key = fold48(fold_src);
            tmps_pkg::TMPS_HASH_SRC:     key = fold48(lk_src_mac);
            tmps_pkg::TMPS_HASH_DST:     key = fold48(lk_dst_mac);
            // source port only honoured in ring mode; else default hash
            tmps_pkg::TMPS_HASH_PORT:    key = lk_ring_mode ? lk_src_port[2:0]
                                                            : fold48(fold_src);
        endcase
    end

    // ==========================================================
    // trunk resolution per group
    logic [7:0] src_grp_mask;  // ports in the ingress trunk
    logic [7:0] grp_keep [tmps_pkg::TMPS_NUM_GROUPS];
    logic [7:0] trunk_ports;
    logic [7:0] keep_all;
    always_comb begin
        src_grp_mask = 8'h00;
        trunk_ports  = 8'h00;
        keep_all     = 8'h00;
        for (int g = 0; g < tmps_pkg::TMPS_NUM_GROUPS; g++) begin
            grp_keep[g] = 8'h00;
            grp_keep[g][sel_tbl[g*tmps_pkg::TMPS_NUM_ENTRIES + int'(key)]] = 1'b1;
            grp_keep[g] = grp_keep[g] & member[g];
            trunk_ports = trunk_ports | member[g];
            keep_all    = keep_all | grp_keep[g];
            if (lk_src_port < 4'(tmps_pkg::TMPS_NUM_ACCESS) && member[g][lk_src_port[2:0]]) begin
                src_grp_mask = src_grp_mask | member[g];
            end
        end
    end

    // monitor configuration
    logic [9:0] mon_mask;
    logic [9:0] mon0_bit;
    logic [9:0] mon1_bit;
    always_comb begin
        mon0_bit = 10'h000;
        mon1_bit = 10'h000;
        if (mirror_ctrl[tmps_pkg::TMPS_MC_MON0_EN]) begin
            mon0_bit[mirror_ctrl[tmps_pkg::TMPS_MC_MON0 +: 4]] = 1'b1;
        end
        if (mirror_ctrl[tmps_pkg::TMPS_MC_MON1_EN]) begin
            mon1_bit[mirror_ctrl[tmps_pkg::TMPS_MC_MON1 +: 4]] = 1'b1;
        end
        mon_mask = mon0_bit | mon1_bit;
    end

    // normal destination set
    logic [9:0] next_dest;
    logic       next_drop;
    logic [9:0] src_bit;
    always_comb begin
        src_bit   = 10'h000;
        src_bit[lk_src_port] = 1'b1;
        next_drop = 1'b0;
        if (!lk_multicast) begin
            next_dest = lk_dest_set;
            if (lk_dst_is_trunk) begin
                // group fetched from the entry's trunk number
                if (lk_src_port < 4'(tmps_pkg::TMPS_NUM_ACCESS) &&
                    member[lk_dst_trunk][lk_src_port[2:0]]) begin
                    next_drop = 1'b1;
                    next_dest = 10'h000;
                end else begin
                    next_dest = {2'b00, grp_keep[lk_dst_trunk]};
                end
            end
        end else begin
            // exclusion first, then one port per group
            next_dest = lk_dest_set & ~src_bit & ~{2'b00, src_grp_mask};
            next_dest = next_dest & ~{2'b00, trunk_ports & ~keep_all};
        end
        next_dest = next_dest & ~mon_mask;
    end

    // mirror copies; ingress port may be a monitor for loopback
    logic [9:0] next_mirror;
    logic [2:0] psrc;
    logic       flow_hit;
    logic       addr_hit;
    always_comb begin
        psrc        = mirror_ctrl[tmps_pkg::TMPS_MC_PORT_SRC +: 3];
        next_mirror = 10'h000;
        addr_hit    = mirror_ctrl[tmps_pkg::TMPS_MC_ADDR_EN] &
                      (lk_src_mirror | lk_dst_mirror);
        flow_hit    = mirror_ctrl[tmps_pkg::TMPS_MC_FLOW_EN] &
                      ((lk_src_mac == flow_a && lk_dst_mac == flow_b) |
                       (mirror_ctrl[tmps_pkg::TMPS_MC_FLOW_REV] &
                        lk_src_mac == flow_b && lk_dst_mac == flow_a));
        if (addr_hit | flow_hit) begin
            next_mirror = mon0_bit;
        end
        if (mirror_ctrl[tmps_pkg::TMPS_MC_PORT_ING] && lk_src_port == {1'b0, psrc}) begin
            next_mirror = next_mirror | mon0_bit;
        end
        if (mirror_ctrl[tmps_pkg::TMPS_MC_PORT_EGR] && next_dest[psrc]) begin
            next_mirror = next_mirror | mon1_bit;
        end
    end

    // ==========================================================
    // registered result, one cycle after lookup
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            qm_valid      <= 1'b0;
            qm_dest_set   <= 10'h000;
            qm_mirror_set <= 10'h000;
            qm_drop       <= 1'b0;
        end else begin
            qm_valid      <= lk_valid;
            qm_dest_set   <= lk_valid ? next_dest : 10'h000;
            qm_mirror_set <= lk_valid ? next_mirror : 10'h000;
            qm_drop       <= lk_valid & next_drop;
        end
    end

    // status counters, saturating
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            drop_count   <= 16'h0000;
            mirror_count <= 16'h0000;
        end else begin
            if (lk_valid && next_drop && drop_count != 16'hffff) begin
                drop_count <= drop_count + 16'h0001;
            end
            if (lk_valid && next_mirror != 10'h000 && mirror_count != 16'hffff) begin
                mirror_count <= mirror_count + 16'h0001;
            end
        end
    end
endmodule : tmps_port_select

/* rtl/tmps_pkg.sv */
// What this block does
// - eight trunk groups, each holding up to eight member ports
// - unicast hash on src+dst mac by default; src, dst, source port options
// - multicast uses the same selectable hash as unicast
// - trunk flag in destination entry fetches its trunk group number
// - unicast from a member of the destination trunk is dropped
// - each trunk has eight member-select entries indexed by hash key
// - hash key is a pure function of addresses, or of source port in ring mode; flows keep one port
// - multicast drops ingress port and all ports of its trunk
// - multicast keeps one hashed port per destination trunk group
// - software rewrites member-select entries after link failure; the map reaches groups 0 to 3 only, groups 4 to 7 keep reset value 0
// - three mirror methods: address, flow and port based
// - address mirror flag with src/dst select copies frame to monitor
// - flow mirror copies frames matching the programmed address pair
// - separate enable also mirrors the swapped address pair
// - port mirror copies ingress or egress traffic of a chosen port
// - at most two monitor ports
// - monitor ports carry only mirrored copies
// - mirroring to the ingress port sends the frame back out it
// - access ports are numbered 0 to 7
// - processor port is number 8 of the ten-port set
package tmps_pkg;
    // ==========================================================
    // register map (word aligned)
    localparam logic [7:0] TMPS_OFS_TRUNK_MEMBER = 8'h00; // 0x00..0x1c, one per group
    localparam logic [7:0] TMPS_OFS_HASH_CTRL    = 8'h20;
    localparam logic [7:0] TMPS_OFS_MIRROR_CTRL  = 8'h24;
    localparam logic [7:0] TMPS_OFS_FLOW_A_LO    = 8'h28;
    localparam logic [7:0] TMPS_OFS_FLOW_A_HI    = 8'h2c;
    localparam logic [7:0] TMPS_OFS_FLOW_B_LO    = 8'h30;
    localparam logic [7:0] TMPS_OFS_FLOW_B_HI    = 8'h34;
    localparam logic [7:0] TMPS_OFS_STATUS       = 8'h38;
    localparam logic [7:0] TMPS_OFS_SELECT       = 8'h40; // 0x40..0xbc, first 32 of the 64 entries
    // ==========================================================
    // sizes and port numbering
    localparam int TMPS_NUM_GROUPS  = 8;
    localparam int TMPS_NUM_ENTRIES = 8;
    localparam int TMPS_NUM_PORTS   = 10;
    localparam int TMPS_NUM_ACCESS  = 8;
    localparam logic [3:0] TMPS_CPU_PORT = 4'h8;
    // ==========================================================
    // hash modes
    typedef enum logic [1:0] {
        TMPS_HASH_SRC_DST = 2'b00,
        TMPS_HASH_SRC     = 2'b01,
        TMPS_HASH_DST     = 2'b10,
        TMPS_HASH_PORT    = 2'b11
    } tmps_hash_t;
    // mirror_ctrl field positions
    localparam int TMPS_MC_MON0    = 0;  // [3:0]
    localparam int TMPS_MC_MON0_EN = 4;
    localparam int TMPS_MC_MON1    = 8;  // [11:8]
    localparam int TMPS_MC_MON1_EN = 12;
    localparam int TMPS_MC_PORT_SRC = 16; // [18:16]
    localparam int TMPS_MC_PORT_ING = 19; // port mirror of ingress to mon0
    localparam int TMPS_MC_PORT_EGR = 20; // port mirror of egress to mon1
    localparam int TMPS_MC_ADDR_EN  = 21;
    localparam int TMPS_MC_FLOW_EN  = 22;
    localparam int TMPS_MC_FLOW_REV = 23;
    localparam logic [31:0] TMPS_MIRROR_RST = 32'h0000_0000;
    localparam logic [31:0] TMPS_HASH_RST   = 32'h0000_0000;
endpackage : tmps_pkg

/* test/tmps_port_select_props.sv */
`timescale 1ns/1ns
// ==========================================================
// decision and bus checks at the selector ports
module tmps_port_select_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // register bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // lookup and decision
    input wire logic        lk_valid,
    input wire logic        lk_multicast,
    input wire logic [3:0]  lk_src_port,
    input wire logic [9:0]  lk_dest_set,
    input wire logic        lk_dst_is_trunk,
    input wire logic        qm_valid,
    input wire logic [9:0]  qm_dest_set,
    input wire logic [9:0]  qm_mirror_set,
    input wire logic        qm_drop
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic rd_q;
    // read data may only show in a read data phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) rd_q <= 1'b0;
        else rd_q <= hsel && hready && htrans[1] && !hwrite;
    end
    sequence s_take;
        lk_valid;
    endsequence
    sequence s_answer;
        qm_valid;
    endsequence
    a_answer_next: assert property (s_take |=> s_answer)
        else $error("no decision one cycle after a lookup");
    a_no_spurious: assert property (qm_valid |-> $past(lk_valid))
        else $error("decision without a lookup");
    a_idle_quiet: assert property (!qm_valid |-> (qm_dest_set == 10'h000
        && qm_mirror_set == 10'h000 && !qm_drop)) else $error("decision outputs not quiet");
    a_ready_high: assert property (hreadyout)
        else $error("bus stalled");
    a_resp_okay: assert property (!hresp)
        else $error("bus error response");
    a_read_idle: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("read data outside read phase");
    a_no_new_port: assert property (lk_valid && !lk_dst_is_trunk
        |=> (qm_dest_set & ~$past(lk_dest_set)) == 10'h000) else $error("port added");
    a_src_excluded: assert property (lk_valid && lk_multicast && lk_src_port < 4'ha
        |=> !qm_dest_set[$past(lk_src_port)]) else $error("multicast back to ingress");
    a_trunk_single: assert property (lk_valid && !lk_multicast && lk_dst_is_trunk
        |=> $onehot0(qm_dest_set)) else $error("trunk unicast to several ports");
endmodule : tmps_port_select_props

bind tmps_port_select tmps_port_select_props u_props (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .lk_valid(lk_valid), .lk_multicast(lk_multicast), .lk_src_port(lk_src_port),
    .lk_dest_set(lk_dest_set), .lk_dst_is_trunk(lk_dst_is_trunk), .qm_valid(qm_valid),
    .qm_dest_set(qm_dest_set), .qm_mirror_set(qm_mirror_set), .qm_drop(qm_drop)
);

/* test/tmps_search_model.sv */
`timescale 1ns/1ns
// ==========================================================
// search engine source and queue manager sink
module tmps_search_model (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // lookup result
    output logic            lk_valid,
    output logic            lk_multicast,
    output logic [47:0]     lk_src_mac,
    output logic [47:0]     lk_dst_mac,
    output logic [3:0]      lk_src_port,
    output logic [9:0]      lk_dest_set,
    output logic            lk_dst_is_trunk,
    output logic [2:0]      lk_dst_trunk,
    output logic            lk_src_mirror,
    output logic            lk_dst_mirror,
    output logic            lk_ring_mode,
    // decision
    input wire logic        qm_valid,
    input wire logic [9:0]  qm_dest_set,
    input wire logic [9:0]  qm_mirror_set,
    input wire logic        qm_drop
);
    logic [9:0] got_dest, got_mir;
    logic       got_drop;
    int         got_n;
    // quiet lookup lines at time zero
    initial begin
        {lk_valid, lk_multicast, lk_src_mac, lk_dst_mac, lk_src_port} = '0;
        {lk_dest_set, lk_dst_is_trunk, lk_dst_trunk, lk_src_mirror} = '0;
        {lk_dst_mirror, lk_ring_mode} = '0;
    end
    // the queue manager keeps the last decision
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) got_n <= 0;
        else if (qm_valid) begin
            got_dest <= qm_dest_set;
            got_mir  <= qm_mirror_set;
            got_drop <= qm_drop;
            got_n    <= got_n + 1;
        end
    end
    // one lookup pulse, then stale mac and dest-set fields are scrambled, not held
    task automatic send(input logic mc, input logic [3:0] sp, input logic [47:0] s, d,
        input logic [9:0] ds, input logic tr, input logic [2:0] tg, input logic sm, dm, rg);
        @(posedge clk);
        lk_valid        <= 1'b1;
        lk_multicast    <= mc;
        lk_src_port     <= sp;
        lk_src_mac      <= s;
        lk_dst_mac      <= d;
        lk_dest_set     <= ds;
        lk_dst_is_trunk <= tr;
        lk_dst_trunk    <= tg;
        lk_src_mirror   <= sm;
        lk_dst_mirror   <= dm;
        lk_ring_mode    <= rg;
        @(posedge clk);
        lk_valid    <= 1'b0;
        lk_src_mac  <= ~s;
        lk_dst_mac  <= ~d;
        lk_dest_set <= ~ds;
        @(posedge clk);
        #1;
    endtask : send
endmodule : tmps_search_model

/* test/tmps_port_select_tb.sv */
`timescale 1ns/1ns
// ==========================================================
// selector bench
module tmps_port_select_tb;
    logic        clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, lk_dst_trunk;
    logic        lk_valid, lk_multicast, lk_dst_is_trunk, lk_src_mirror;
    logic        lk_dst_mirror, lk_ring_mode, qm_valid, qm_drop;
    logic [47:0] lk_src_mac, lk_dst_mac;
    logic [3:0]  lk_src_port;
    logic [9:0]  lk_dest_set, qm_dest_set, qm_mirror_set;
    int          n_mismatch, check_count, n_frames;
    assign hready = hreadyout;
    tmps_port_select dut (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lk_valid(lk_valid),
        .lk_multicast(lk_multicast), .lk_src_mac(lk_src_mac), .lk_dst_mac(lk_dst_mac),
        .lk_src_port(lk_src_port), .lk_dest_set(lk_dest_set), .lk_dst_trunk(lk_dst_trunk),
        .lk_dst_is_trunk(lk_dst_is_trunk), .lk_src_mirror(lk_src_mirror),
        .lk_dst_mirror(lk_dst_mirror), .lk_ring_mode(lk_ring_mode), .qm_valid(qm_valid),
        .qm_dest_set(qm_dest_set), .qm_mirror_set(qm_mirror_set), .qm_drop(qm_drop));
    tmps_search_model u_se (
        .clk(clk), .reset_n(reset_n), .lk_valid(lk_valid), .lk_multicast(lk_multicast),
        .lk_src_mac(lk_src_mac), .lk_dst_mac(lk_dst_mac), .lk_src_port(lk_src_port),
        .lk_dest_set(lk_dest_set), .lk_dst_is_trunk(lk_dst_is_trunk),
        .lk_dst_trunk(lk_dst_trunk), .lk_src_mirror(lk_src_mirror),
        .lk_dst_mirror(lk_dst_mirror), .lk_ring_mode(lk_ring_mode), .qm_valid(qm_valid),
        .qm_dest_set(qm_dest_set), .qm_mirror_set(qm_mirror_set), .qm_drop(qm_drop));
    // ==========================================================
    // helpers
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp
    // one single word transfer; the address phase is held until ready
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic look(input logic mc, input logic [3:0] sp, input logic [47:0] s, d,
        input logic [9:0] ds, input logic tr, input logic [2:0] tg, input logic sm, dm, rg);
        n_frames++;
        u_se.send(mc, sp, s, d, ds, tr, tg, sm, dm, rg);
        cmp("decision count", n_frames, u_se.got_n);
    endtask : look
    // key is a pure xor fold, so one flow always hashes alike
    function automatic logic [2:0] fold(input logic [47:0] v);
        logic [2:0] k;
        k = 3'h0;
        for (int i = 0; i < 16; i++) k ^= v[3*i +: 3];
        return k;
    endfunction : fold
    // ==========================================================
    // scenarios
    task automatic t_regs;
        logic [31:0] v;
        bus(1'b0, 32'h20, 32'h0, v);
        cmp("hash reset", 32'h0, v);
        bus(1'b0, 32'h24, 32'h0, v);
        cmp("mirror reset", 32'h0, v);
        bus(1'b1, 32'h20, 32'h2, v);
        bus(1'b0, 32'h20, 32'h0, v);
        cmp("hash mode", 32'h2, v);
        bus(1'b1, 32'hfc, 32'hffff_ffff, v);
        bus(1'b0, 32'hfc, 32'h0, v);
        cmp("unmapped", 32'h0, v);
        bus(1'b1, 32'h20, 32'h0, v);
    endtask : t_regs
    task automatic t_mirror;
        logic [31:0] v;
        logic [47:0] a, b;
        a = 48'h0a1b_2c3d_4e5f;
        b = 48'h1122_3344_5566;
        bus(1'b1, 32'h28, a[31:0], v);
        bus(1'b1, 32'h2c, {16'h0, a[47:32]}, v);
        bus(1'b1, 32'h30, b[31:0], v);
        bus(1'b1, 32'h34, {16'h0, b[47:32]}, v);
        bus(1'b1, 32'h24, 32'h0079_1617, v);
        look(0, 2, 48'h1, 48'h2, 10'h008, 0, 0, 1, 0, 0);
        cmp("dest kept", 32'h008, u_se.got_dest);
        cmp("addr src mirror", 32'h080, u_se.got_mir);
        look(0, 2, 48'h1, 48'h2, 10'h008, 0, 0, 0, 1, 0);
        cmp("addr dst mirror", 32'h080, u_se.got_mir);
        look(0, 2, a, b, 10'h008, 0, 0, 0, 0, 0);
        cmp("flow mirror", 32'h080, u_se.got_mir);
        look(0, 2, b, a, 10'h008, 0, 0, 0, 0, 0);
        cmp("reverse off", 32'h000, u_se.got_mir);
        look(0, 1, 48'h1, 48'h2, 10'h008, 0, 0, 0, 0, 0);
        cmp("ingress mirror", 32'h080, u_se.got_mir);
        look(0, 2, 48'h1, 48'h2, 10'h002, 0, 0, 0, 0, 0);
        cmp("egress mirror", 32'h040, u_se.got_mir);
        cmp("egress dest", 32'h002, u_se.got_dest);
        look(0, 2, 48'h1, 48'h2, 10'h080, 0, 0, 0, 0, 0);
        cmp("monitor excluded", 32'h000, u_se.got_dest);
        bus(1'b1, 32'h24, 32'h00f9_1617, v);
        look(0, 2, b, a, 10'h008, 0, 0, 0, 0, 0);
        cmp("reverse on", 32'h080, u_se.got_mir);
        bus(1'b1, 32'h24, 32'h000a_0012, v);
        look(0, 2, 48'h1, 48'h2, 10'h008, 0, 0, 0, 0, 0);
        cmp("loopback", 32'h004, u_se.got_mir);
        bus(1'b1, 32'h24, 32'h0, v);
    endtask : t_mirror
    task automatic t_trunk;
        logic [31:0] v;
        logic [47:0] s, d;
        logic [2:0]  k;
        s = 48'h02a4_77c1_9e05;
        d = 48'h5b10_e3f2_8866;
        bus(1'b1, 32'h08, 32'he0, v);
        for (int i = 0; i < 8; i++) bus(1'b1, 32'h80 + 4 * i, 32'(5 + i % 3), v);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 32'h20, (i == 4) ? 32'h3 : 32'(i), v);
            k = fold(s ^ d);
            if (i == 1) k = fold(s);
            if (i == 2) k = fold(d);
            if (i == 3) k = 3'd1;
            look(0, 1, s, d, 10'h020, 1, 2, 0, 0, i == 3);
            cmp("trunk port", 32'(1) << 5 + k % 3, u_se.got_dest);
            cmp("no drop", 32'h0, u_se.got_drop);
        end
        look(0, 6, s, d, 10'h020, 1, 2, 0, 0, 0);
        cmp("member drop", 32'h1, u_se.got_drop);
        bus(1'b1, 32'h20, 32'h0, v);
        for (int i = 0; i < 8; i++) bus(1'b1, 32'h80 + 4 * i, 32'h5, v);
        look(0, 1, s, d, 10'h020, 1, 2, 0, 0, 0);
        cmp("survivor port", 32'h020, u_se.got_dest);
        bus(1'b1, 32'h00, 32'h07, v);
        bus(1'b1, 32'h04, 32'h18, v);
        bus(1'b1, 32'h08, 32'h00, v);
        for (int i = 0; i < 8; i++) bus(1'b1, 32'h40 + 4 * i, 32'(i % 3), v);
        k = fold(s ^ d);
        look(1, 3, s, d, 10'h17f, 0, 0, 0, 0, 0);
        v = 32'h160 | 32'(1) << k % 3;
        cmp("multicast set", v, u_se.got_dest);
    endtask : t_trunk
    // ==========================================================
    // verdict, clock, watchdog, main sequence
    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end
    initial begin
        {hsel, hwrite, haddr, hwdata, htrans} = '0;
        hsize   = 3'b010;
        reset_n = 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_mirror();
        t_trunk();
        results();
    end
endmodule : tmps_port_select_tb
